// [pkg/bwcp_pkg.sv]
// Constants for the byte-wide configuration port: register addresses, commands, layouts.
// Assumes a single clock domain driven by the configuration clock.
`default_nettype none
package bwcp_pkg;
   localparam logic [3:0] BWCP_ADDR_CRC    = 4'h0;
   localparam logic [3:0] BWCP_ADDR_FRAME_ADDR = 4'h1;
   localparam logic [3:0] BWCP_ADDR_FRAME_IN   = 4'h2;
   localparam logic [3:0] BWCP_ADDR_FRAME_OUT  = 4'h3;
   localparam logic [3:0] BWCP_ADDR_CMD        = 4'h4;
   localparam logic [3:0] BWCP_ADDR_CONTROL    = 4'h5;
   localparam logic [3:0] BWCP_ADDR_MASK       = 4'h6;
   localparam logic [3:0] BWCP_ADDR_CHAIN_OUT  = 4'h8;
   localparam logic [3:0] BWCP_ADDR_OPTIONS    = 4'h9;
   localparam logic [3:0] BWCP_ADDR_FRAME_LEN  = 4'hb;
   localparam logic [3:0] BWCP_CMD_RCHK    = 4'h7;
   localparam logic [3:0] BWCP_CMD_SWITCH  = 4'h9;
   localparam logic [3:0] BWCP_CMD_FWRITE  = 4'h1;
   localparam logic [3:0] BWCP_CMD_FREAD   = 4'h4;
   localparam logic [3:0] BWCP_CMD_LAST    = 4'h3;
   localparam logic [3:0] BWCP_CMD_START   = 4'h5;
   localparam logic [31:0] BWCP_SYNC_WORD  = 32'haa995566;
   // Packet header fields
   localparam int BWCP_HDR_TYPE_LSB = 29;
   localparam int BWCP_HDR_OP_LSB   = 27;
   localparam int BWCP_HDR_ADDR_LSB = 13;
   localparam int BWCP_HDR_CNT_LSB  = 0;
   localparam logic [2:0] BWCP_TYPE1 = 3'h1;
   localparam logic [1:0] BWCP_OP_WRITE = 2'h2;
   localparam logic [1:0] BWCP_OP_READ  = 2'h1;
   localparam logic [31:0] BWCP_REG_RESET = 32'h00000000;
   localparam int BWCP_FRAME_BITS_MIN = 384;
   localparam int BWCP_FRAME_BITS_MAX = 1952;
   typedef enum logic [2:0] {BWCP_IDLE, BWCP_HUNT, BWCP_HEADER, BWCP_DATA,
                             BWCP_ABORT, BWCP_ERROR, BWCP_DONE} bwcp_state_t;
endpackage
`default_nettype wire

// [rtl/bwcp_port.sv]
// Byte-wide configuration port: assembles bytes into words, routes packet
// data into the addressed configuration registers and decodes commands.
// Assumes clk is the configuration clock driven by the host; select and
// write strobe pins are synchronous to it, so no resynchronising stages.
`timescale 1ns/1ps
`default_nettype none
module bwcp_port
   import bwcp_pkg::*;
#(
   parameter int FRAME_BITS  = BWCP_FRAME_BITS_MIN,
   parameter int FRAME_COUNT = 1453
) (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        init_in,
   input  wire logic        select_n,
   input  wire logic        write_n,
   input  wire logic [7:0]  config_data_byte_in,
   output logic      [7:0]  config_data_byte_out,
   output logic             config_data_byte_oe,
   output logic             busy_out,
   output logic             busy_oe,
   output logic             init_low_oe,
   output logic             aborted,
   output logic             start_up,
   output logic             frame_write_en,
   output logic [31:0]      frame_address_reg,
   output logic [31:0]      frame_length_reg,
   output logic [31:0]      config_options_reg,
   output logic [31:0]      control_reg,
   output logic [31:0]      word_data,
   output logic             word_strobe
);
   bwcp_state_t state_r;
   logic [31:0] shift_r;
   logic [1:0]  byte_cnt_r;
   logic [3:0]  addr_r;
   logic [10:0] words_left_r;
   logic        word_op_read_r;
   logic [31:0] crc_r;
   logic [31:0] mask_r;
   logic [31:0] chain_data_out_reg;
   logic        readback_en_r;
   logic        last_frame_r;
   logic        active;
   logic        take_byte;
   logic [7:0]  byte_msb;
   logic [31:0] word_nxt;
   logic        word_done;
   logic        cmd_taken;
   logic [10:0] frame_word_r;
   logic        frame_end;

   // Port is live only after init rose and while no abort or error stands
   assign active = init_in && !select_n && state_r != BWCP_ABORT
                   && state_r != BWCP_ERROR && state_r != BWCP_DONE;
   // Busy never asserts here, so every enabled edge takes a byte
   assign take_byte = active && !write_n && !busy_out;
   // Bit 0 of the pins carries the most significant bit
   generate
      for (genvar i = 0; i < 8; i++) begin : g_rev
         assign byte_msb[7-i] = config_data_byte_in[i];
      end
   endgenerate
   assign word_nxt  = {shift_r[23:0], byte_msb};
   assign word_done = take_byte && (state_r == BWCP_HUNT || byte_cnt_r == 2'h3);
   // A data word of a command packet is being taken
   assign cmd_taken = word_done && state_r == BWCP_DATA && addr_r == BWCP_ADDR_CMD;
   assign frame_end = frame_word_r >= frame_length_reg[10:0];

   // Word position inside the current frame, restarted by each frame write command
   always_ff @(posedge clk) begin
      if (reset) begin
         frame_word_r <= 11'h000;
      end else if (cmd_taken && word_nxt[3:0] == BWCP_CMD_FWRITE) begin
         frame_word_r <= 11'h000;
      end else if (word_done && state_r == BWCP_DATA && addr_r == BWCP_ADDR_FRAME_IN
                   && frame_write_en) begin
         if (frame_end) begin
            frame_word_r <= 11'h000;
         end else begin
            frame_word_r <= frame_word_r + 11'h001;
         end
      end
   end

   // State sequencing, including abort on a released strobe
   always_ff @(posedge clk) begin
      if (reset) begin
         state_r <= BWCP_IDLE;
      end else if (active && write_n && !readback_en_r) begin
         state_r <= BWCP_ABORT;
      end else if (take_byte) begin
         case (state_r)
            BWCP_IDLE: state_r <= BWCP_HUNT;
            BWCP_HUNT: if (word_nxt == BWCP_SYNC_WORD) state_r <= BWCP_HEADER;
            BWCP_HEADER: if (word_done
                             && word_nxt[31:29] == BWCP_TYPE1
                             && word_nxt[10:0] != 11'h000) state_r <= BWCP_DATA;
            BWCP_DATA: if (word_done && words_left_r == 11'h001) begin
               if (addr_r == BWCP_ADDR_CRC && word_nxt != crc_r) begin
                  state_r <= BWCP_ERROR;
               end else if (addr_r == BWCP_ADDR_CMD && word_nxt[3:0] == BWCP_CMD_START) begin
                  state_r <= BWCP_HEADER;
               end else begin
                  state_r <= BWCP_HEADER;
               end
            end
            default: state_r <= state_r;
         endcase
      end
   end

   // Byte assembly; sync hunt shifts on every byte
   always_ff @(posedge clk) begin
      if (reset) begin
         shift_r    <= 32'h00000000;
         byte_cnt_r <= 2'h0;
      end else if (take_byte) begin
         shift_r    <= word_nxt;
         byte_cnt_r <= (state_r == BWCP_HUNT || state_r == BWCP_IDLE) ? 2'h0 : byte_cnt_r + 2'h1;
      end
   end

   // Header decode: register address and word count
   always_ff @(posedge clk) begin
      if (reset) begin
         addr_r         <= 4'h0;
         words_left_r   <= 11'h000;
         word_op_read_r <= 1'b0;
      end else if (word_done && state_r == BWCP_HEADER) begin
         addr_r         <= word_nxt[16:13];
         words_left_r   <= word_nxt[10:0];
         word_op_read_r <= word_nxt[28:27] == BWCP_OP_READ;
      end else if (word_done && state_r == BWCP_DATA) begin
         words_left_r   <= words_left_r - 11'h001;
      end
   end

   // Register writes routed by address
   always_ff @(posedge clk) begin
      if (reset) begin
         frame_address_reg  <= BWCP_REG_RESET;
         frame_length_reg   <= BWCP_REG_RESET;
         config_options_reg <= BWCP_REG_RESET;
         control_reg        <= BWCP_REG_RESET;
         mask_r             <= BWCP_REG_RESET;
         crc_r              <= BWCP_REG_RESET;
         chain_data_out_reg <= BWCP_REG_RESET;
      end else if (word_done && state_r == BWCP_DATA && !word_op_read_r) begin
         case (addr_r)
            BWCP_ADDR_FRAME_ADDR: frame_address_reg  <= word_nxt;
            BWCP_ADDR_FRAME_LEN:  frame_length_reg   <= word_nxt;
            BWCP_ADDR_OPTIONS:    config_options_reg <= word_nxt;
            BWCP_ADDR_MASK:       mask_r             <= word_nxt;
            BWCP_ADDR_CONTROL:    control_reg <= (control_reg & ~mask_r) | (word_nxt & mask_r);
            BWCP_ADDR_CRC:        crc_r              <= word_nxt;
            BWCP_ADDR_CHAIN_OUT:  chain_data_out_reg <= word_nxt;
            default: crc_r <= crc_r;
         endcase
      end
   end

   // Command decode
   always_ff @(posedge clk) begin
      if (reset) begin
         frame_write_en <= 1'b0;
         readback_en_r  <= 1'b0;
         last_frame_r   <= 1'b0;
         start_up       <= 1'b0;
      end else if (word_done && state_r == BWCP_DATA && addr_r == BWCP_ADDR_CMD) begin
         case (word_nxt[3:0])
            BWCP_CMD_RCHK:   last_frame_r   <= 1'b0;
            BWCP_CMD_SWITCH: last_frame_r   <= last_frame_r;
            BWCP_CMD_FWRITE: frame_write_en <= 1'b1;
            BWCP_CMD_FREAD:  readback_en_r  <= 1'b1;
            BWCP_CMD_LAST:   last_frame_r   <= 1'b1;
            BWCP_CMD_START:  start_up       <= 1'b1;
            default:         frame_write_en <= frame_write_en;
         endcase
      end
   end

   // Frame data words leave as a one-cycle strobe
   always_ff @(posedge clk) begin
      if (reset) begin
         word_data   <= 32'h00000000;
         word_strobe <= 1'b0;
      end else begin
         word_strobe <= word_done && state_r == BWCP_DATA && addr_r == BWCP_ADDR_FRAME_IN
                        && frame_write_en;
         if (word_done) word_data <= word_nxt;
      end
   end

   // Pin drivers: busy, init, and readback bus
   always_ff @(posedge clk) begin
      if (reset) begin
         busy_out             <= 1'b0;
         busy_oe              <= 1'b0;
         init_low_oe          <= 1'b0;
         aborted              <= 1'b0;
         config_data_byte_out <= 8'h00;
         config_data_byte_oe  <= 1'b0;
      end else begin
         busy_out    <= 1'b0;
         busy_oe     <= !select_n;
         init_low_oe <= init_low_oe || (take_byte && state_r == BWCP_DATA && word_done
                        && words_left_r == 11'h001 && addr_r == BWCP_ADDR_CRC
                        && word_nxt != crc_r);
         aborted     <= state_r == BWCP_ABORT;
         config_data_byte_out <= 8'h00;
         config_data_byte_oe  <= !select_n && write_n && readback_en_r;
      end
   end

   a_oe_deselect: assert property (@(posedge clk) disable iff (reset)
      select_n |=> !config_data_byte_oe) else $error("bus driven while deselected");
   a_busy_tristate: assert property (@(posedge clk) disable iff (reset)
      select_n |=> !busy_oe) else $error("busy driven while deselected");
   a_abort_sticky: assert property (@(posedge clk) disable iff (reset)
      state_r == BWCP_ABORT |=> state_r == BWCP_ABORT) else $error("abort left without reset");
   a_strobe_abort: assert property (@(posedge clk) disable iff (reset)
      active && write_n && !readback_en_r |=> state_r == BWCP_ABORT ##1 aborted)
      else $error("released strobe did not abort");
   a_init_gate: assert property (@(posedge clk) disable iff (reset)
      !init_in |-> !take_byte) else $error("byte taken before init");
   a_byte_shift: assert property (@(posedge clk) disable iff (reset)
      take_byte |=> shift_r[0] == $past(config_data_byte_in[7])) else $error("bit order wrong");
   a_idle_hold: assert property (@(posedge clk) disable iff (reset)
      select_n |=> shift_r == $past(shift_r)) else $error("deselected edge changed data");
   a_crc_error: assert property (@(posedge clk) disable iff (reset)
      state_r == BWCP_ERROR |-> ##1 init_low_oe [*2]) else $error("init not held low");

   // Protocol and register checks
   a_take_select: assert property (@(posedge clk) disable iff (reset)
      select_n |-> !take_byte)
      else $error("byte taken while deselected");
   a_busy_driven: assert property (@(posedge clk) disable iff (reset)
      !select_n |=> busy_oe)
      else $error("busy not driven while selected");
   a_readback_oe: assert property (@(posedge clk) disable iff (reset)
      config_data_byte_oe |-> $past(readback_en_r) && $past(write_n))
      else $error("bus driven outside readback");
   a_error_sticky: assert property (@(posedge clk) disable iff (reset)
      state_r == BWCP_ERROR |=> state_r == BWCP_ERROR)
      else $error("checksum error left without reset");
   a_init_low_hold: assert property (@(posedge clk) disable iff (reset)
      init_low_oe |=> init_low_oe)
      else $error("init released after checksum error");
   a_abort_flag: assert property (@(posedge clk) disable iff (reset)
      aborted |=> aborted)
      else $error("abort flag dropped without reset");
   a_ignore_abort: assert property (@(posedge clk) disable iff (reset)
      state_r == BWCP_ABORT |-> !take_byte)
      else $error("byte taken after abort");
   a_hunt_sync: assert property (@(posedge clk) disable iff (reset)
      state_r == BWCP_HUNT && take_byte && word_nxt == BWCP_SYNC_WORD |=> state_r == BWCP_HEADER)
      else $error("sync word not recognised");
   a_write_capture: assert property (@(posedge clk) disable iff (reset)
      word_done && state_r == BWCP_DATA && !word_op_read_r && addr_r == BWCP_ADDR_FRAME_LEN
      |=> frame_length_reg == $past(word_nxt))
      else $error("frame length not written");
   a_startup_cmd: assert property (@(posedge clk) disable iff (reset)
      cmd_taken && word_nxt[3:0] == BWCP_CMD_START |=> start_up)
      else $error("start command not decoded");
   a_frame_restart: assert property (@(posedge clk) disable iff (reset)
      cmd_taken && word_nxt[3:0] == BWCP_CMD_FWRITE |=> frame_word_r == 11'h000)
      else $error("frame position not restarted");
   a_strobe_pulse: assert property (@(posedge clk) disable iff (reset)
      word_strobe |=> !word_strobe)
      else $error("frame word strobe longer than one cycle");

   // Scenario covers
   c_sync_found: cover property (@(posedge clk) state_r == BWCP_HUNT ##1 state_r == BWCP_HEADER);
   c_frame_word: cover property (@(posedge clk) word_strobe);
   c_abort: cover property (@(posedge clk) aborted);
   c_readback: cover property (@(posedge clk) config_data_byte_oe);
   c_crc_fail: cover property (@(posedge clk) init_low_oe);
endmodule
`default_nettype wire

// [test/bwcp_host.sv]
// Host model: drives select, write strobe and data pins of the port.
// Assumes the bench calls its tasks while clk runs; pins change on falling edges, and a wiggle pulse ends 2 ns after one.
`timescale 1ns/1ps
`default_nettype none
module bwcp_host (
   input  wire logic       clk,
   output logic            select_n,
   output logic            write_n,
   output logic [7:0]      data
);
   initial begin
      select_n = 1'b1;
      write_n  = 1'b0;
      data     = 8'h00;
   end
   // Optional deselect gap before the byte; wiggle pulses the strobe between edges
   task automatic send_byte(input logic [7:0] b, input int gap, input bit wig);
      @(negedge clk);
      for (int i = 0; i < gap; i++) begin
         select_n = 1'b1;
         data     = ~data;
         @(negedge clk);
      end
      select_n = 1'b0;
      data     = {<<{b}};
      if (wig) begin
         write_n = 1'b1;
         #2;
      end
      write_n  = 1'b0;
      @(posedge clk);
   endtask
   task automatic release_bus();
      @(negedge clk);
      select_n = 1'b1;
      write_n  = 1'b0;
      data     = ~data;
   endtask
   task automatic strobe_high();
      @(negedge clk);
      select_n = 1'b0;
      write_n  = 1'b1;
      @(posedge clk);
   endtask
endmodule
`default_nettype wire

// [test/byte_wide_config_port_tb.sv]
// Bench for the byte-wide configuration port: packet writes, gaps, abort.
// Assumes the host model drives the pins; bench drives clk, reset and init.
`timescale 1ns/1ps
`default_nettype none
module byte_wide_config_port_tb;
   import bwcp_pkg::*;
   logic            clk, reset, init_in;
   logic            oe, boe, bsy, ilo, abt, su, fwe, ws;
   wire logic       sel_n, wr_n;
   wire logic [7:0] din;
   logic [7:0]      dout;
   logic [31:0]     fa_v, fl_v, op_v, ct_v, wd;
   int              n_errors = 0, checks = 0, ws_cnt = 0, oe_cnt = 0;
   logic [3:0]      cmds [5] = '{BWCP_CMD_RCHK, BWCP_CMD_SWITCH, BWCP_CMD_FWRITE,
                                 BWCP_CMD_FREAD, BWCP_CMD_LAST};
   bwcp_host host (.clk(clk), .select_n(sel_n), .write_n(wr_n), .data(din));
   bwcp_port dut (.clk(clk), .reset(reset), .init_in(init_in), .select_n(sel_n),
      .write_n(wr_n), .config_data_byte_in(din), .config_data_byte_out(dout),
      .config_data_byte_oe(oe), .busy_out(bsy), .busy_oe(boe), .init_low_oe(ilo),
      .aborted(abt), .start_up(su), .frame_write_en(fwe), .frame_address_reg(fa_v),
      .frame_length_reg(fl_v), .config_options_reg(op_v), .control_reg(ct_v),
      .word_data(wd), .word_strobe(ws));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (ws === 1'b1) ws_cnt++;
      if (oe === 1'b1) oe_cnt++;
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wword(input logic [31:0] w, input int gap, input bit wig);
      for (int i = 3; i >= 0; i--)
         host.send_byte(w[8*i +: 8], gap, wig);
   endtask
   task automatic wreg(input logic [3:0] a, input logic [31:0] d, input int gap, input bit wig);
      wword(32'h30000001 | (32'(a) << 13), gap, wig);
      wword(d, gap, wig);
   endtask
   task automatic finish_test;
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      finish_test();
   end
   initial begin
      reset = 1'b1;
      init_in = 1'b0;
      repeat (6) @(negedge clk);
      reset = 1'b0;
      wword(BWCP_SYNC_WORD, 0, 0);
      wreg(BWCP_ADDR_FRAME_LEN, 32'h14, 0, 0);
      host.release_bus();
      chk("len_noinit", fl_v, 32'h0);
      init_in = 1'b1;
      wword(BWCP_SYNC_WORD, 0, 0);
      wreg(BWCP_ADDR_FRAME_LEN, 32'h14, 0, 0);
      #1;
      chk("busy_oe_on", boe, 32'h1);
      chk("busy", bsy, 32'h0);
      host.release_bus();
      chk("len", fl_v, 32'h14);
      @(negedge clk);
      chk("busy_oe_off", boe, 32'h0);
      wreg(BWCP_ADDR_OPTIONS, 32'h12345678, 2, 0);
      wreg(BWCP_ADDR_FRAME_ADDR, 32'h00000abc, 1, 1);
      wreg(BWCP_ADDR_MASK, 32'h0000ff00, 0, 0);
      wreg(BWCP_ADDR_CONTROL, 32'hffffffff, 0, 0);
      foreach (cmds[i])
         wreg(BWCP_ADDR_CMD, {28'h0, cmds[i]}, 0, 0);
      host.strobe_high();
      host.release_bus();
      chk("rb_oe", oe, 32'h1);
      chk("rb_data", dout, 32'h0);
      wreg(BWCP_ADDR_FRAME_IN, 32'hcafef00d, 0, 0);
      host.release_bus();
      chk("wd", wd, 32'hcafef00d);
      chk("su_early", su, 32'h0);
      wreg(BWCP_ADDR_CMD, {28'h0, BWCP_CMD_START}, 0, 0);
      host.release_bus();
      @(negedge clk);
      chk("options", op_v, 32'h12345678);
      chk("frame_addr", fa_v, 32'h00000abc);
      chk("control", ct_v, 32'h0000ff00);
      chk("fwe", fwe, 32'h1);
      chk("su", su, 32'h1);
      chk("ws_cnt", ws_cnt, 32'h1);
      reset = 1'b1;
      @(negedge clk);
      reset = 1'b0;
      chk("len_rst", fl_v, 32'h0);
      wword(BWCP_SYNC_WORD, 0, 0);
      host.strobe_high();
      wword(BWCP_SYNC_WORD, 0, 0);
      wreg(BWCP_ADDR_FRAME_LEN, 32'h55, 0, 0);
      host.release_bus();
      chk("abt", abt, 32'h1);
      chk("len_abt", fl_v, 32'h0);
      chk("ilo", ilo, 32'h0);
      reset = 1'b1;
      @(negedge clk);
      reset = 1'b0;
      chk("abt_rst", abt, 32'h0);
      wword(BWCP_SYNC_WORD, 0, 0);
      wreg(BWCP_ADDR_CRC, 32'h0, 0, 0);
      host.release_bus();
      chk("crc_ok", ilo, 32'h0);
      wreg(BWCP_ADDR_CRC, 32'h1, 0, 0);
      wreg(BWCP_ADDR_FRAME_LEN, 32'h77, 0, 0);
      host.release_bus();
      chk("crc_bad", ilo, 32'h1);
      chk("len_err", fl_v, 32'h0);
      chk("oe_cnt", oe_cnt, 32'h1);
      finish_test();
   end
endmodule
`default_nettype wire
